/* File: hdl/swr_pkg.sv */
/*
 * Shared constants for the single-wire identity link: command codes,
 * identity layout, slot and reset timing, master operation codes and
 * the check-byte function.
 * Assumes a 100 MHz clock on both ends.
 */
package swr_pkg;

    // ------------------------------------------------------------
    // Clock, widths
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int CNT_W  = 20;
    localparam int ID_W   = 64;
    localparam int FAM_W  = 8;
    localparam int SER_W  = 48;
    localparam int CRC_W  = 8;
    localparam int BYTE_W = 8;
    localparam int IDX_W  = 6;
    localparam logic [IDX_W-1:0] IDX_LAST  = 6'h3f;
    localparam logic [2:0]       BIT_LAST  = 3'h7;
    localparam logic [1:0]       PH_WRITE  = 2'h2;

    // ------------------------------------------------------------
    // Identity commands
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ID   = 8'h33;
    localparam logic [7:0] CMD_MATCH_ID  = 8'h55;
    localparam logic [7:0] CMD_SKIP_ID   = 8'hcc;
    localparam logic [7:0] CMD_SEARCH_ID = 8'hf0;

    // Check polynomial x8+x5+x4+1, shifted LSB first
    localparam logic [CRC_W-1:0] CRC_POLY_REV = 8'h8c;
    localparam logic [CRC_W-1:0] CRC_INIT     = 8'h00;

    // ------------------------------------------------------------
    // Times in ns, as on the wire
    // ------------------------------------------------------------
    localparam int BUS_RST_NS   = 480000; // low longer than this resets
    localparam int PRES_WAIT_NS = 30000;
    localparam int PRES_LOW_NS  = 120000;
    localparam int DEV_WIN_NS   = 30000;  // device sample / hold point
    localparam int M_RSTLOW_NS  = 485000;
    localparam int M_INIT_NS    = 960000;
    localparam int M_PSAMP_NS   = 70000;
    localparam int M_SLOT_NS    = 61000;
    localparam int M_LOW1_NS    = 5000;
    localparam int M_LOW0_NS    = 55000;
    localparam int M_RSAMP_NS   = 12000;

    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] DEV_RST_CYC   = CNT_W'((BUS_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] PRES_WAIT_CYC = CNT_W'((PRES_WAIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] PRES_END_CYC  =
        CNT_W'((PRES_WAIT_NS + PRES_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] DEV_WIN_CYC   = CNT_W'((DEV_WIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] M_RSTLOW_CYC  = CNT_W'((M_RSTLOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] M_INIT_CYC    = CNT_W'((M_INIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] M_PSAMP_CYC   = CNT_W'((M_PSAMP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] M_SLOT_CYC    = CNT_W'((M_SLOT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] M_LOW1_CYC    = CNT_W'((M_LOW1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] M_LOW0_CYC    = CNT_W'((M_LOW0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] M_RSAMP_CYC   = CNT_W'((M_RSAMP_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------
    // Master operations
    // ------------------------------------------------------------
    localparam logic [1:0] OP_RESET   = 2'h0;
    localparam logic [1:0] OP_WRITE   = 2'h1;
    localparam logic [1:0] OP_READ    = 2'h2;
    localparam logic [1:0] OP_TRIPLET = 2'h3;

    // Check byte over the low 56 identity bits, LSB first from zero
    function automatic logic [CRC_W-1:0] swr_crc8(input logic [FAM_W+SER_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic             fb;
        c = CRC_INIT;
        for (int i = 0; i < FAM_W + SER_W; i++) begin
            fb = c[0] ^ d[i];
            c  = c >> 1;
            if (fb) begin
                c = c ^ CRC_POLY_REV;
            end
        end
        return c;
    endfunction

endpackage

/* File: hdl/swr_link_if.sv */
/*
 * Shared open-drain line between master end and device end.
 * Assumes a pullup: the line is high unless an enabled end drives low.
 */
`timescale 1ns/1ps
interface swr_link_if;
    logic dev_out;
    logic dev_oe;
    logic mst_out;
    logic mst_oe;
    logic line;

    // Wired-AND of both ends, idle high through the pullup
    assign line = (dev_oe ? dev_out : 1'b1) & (mst_oe ? mst_out : 1'b1);

    modport dev (input line, output dev_out, output dev_oe);
    modport mst (input line, output mst_out, output mst_oe);
endinterface

/* File: hdl/swr_dev_end.sv */
/*
 * Device end of the single-wire identity link: reset and presence,
 * identity command decode (read, match, skip, search) and delivery of
 * the following function bytes to local logic.
 * Assumes the master keeps slot timing of swr_pkg and that the line
 * arrives asynchronously.
 */
// Functional notes
// (RULE_01) Hold 64-bit code: family, serial, check
// (RULE_02) All fields travel least significant bit first
// (RULE_03) Drive line only by open-drain pulldown
// (RULE_04) Low beyond 480 us resets the link
// (RULE_05) Idle high; pauses between slots allowed
// (RULE_06) Order: init, identity, function, data
// (RULE_07) Reset pulse answered by presence pulse
// (RULE_08) Identity command taken as eight bits
// (RULE_09) Command 33h sends whole identity code
// (RULE_10) Command 55h selects on full match
// (RULE_11) Mismatch ignores line until next reset
// (RULE_12) Command CCh selects without identity bits
// (RULE_13) Command F0h: bit, complement, master bit
// (RULE_14) Search mismatch drops device from pass
// (RULE_15) Master decodes bit and complement pairs
// (RULE_16) Master reads identity only with one slave
// (RULE_17) Search pass costs init plus slots
// (RULE_18) Function command only after identity done
// (RULE_19) Check byte is x8+x5+x4+1 over 56
// (RULE_20) Reset pulse honoured anywhere, even mid-byte
`timescale 1ns/1ps
module swr_dev_end
    import swr_pkg::*;
#(
    parameter logic [FAM_W-1:0] FAMILY_CODE = 8'h5a,             // arbitrary value
    parameter logic [SER_W-1:0] SERIAL_NUM  = 48'h0123_4567_89ab, // arbitrary value
    parameter logic [CNT_W-1:0] RST_DET_CYC = DEV_RST_CYC
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    swr_link_if.dev                link,
    output logic                   selected,
    output logic                   func_valid,
    output logic                   func_first,
    output logic [BYTE_W-1:0]      func_byte
);

    // ------------------------------------------------------------
    // Identity and states
    // ------------------------------------------------------------
    // (RULE_01) code assembled here
    // (RULE_19) check byte from the family and serial
    localparam logic [ID_W-1:0] ID_CODE =
        {swr_crc8({SERIAL_NUM, FAMILY_CODE}), SERIAL_NUM, FAMILY_CODE};

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_PRES  = 7'h02,
        ST_CMD   = 7'h04,
        ST_READ  = 7'h08,
        ST_MATCH = 7'h10,
        ST_SRCH  = 7'h20,
        ST_FUNC  = 7'h40
    } swr_dst_e;

    swr_dst_e          state;
    logic              line_m;
    logic              line_s;
    logic              line_p;
    logic [CNT_W-1:0]  low_cnt;
    logic              rst_seen;
    logic [CNT_W-1:0]  pres_cnt;
    logic              slot_act;
    logic [CNT_W-1:0]  slot_cnt;
    logic [IDX_W-1:0]  idx;
    logic [1:0]        phase;
    logic [2:0]        bcnt;
    logic [BYTE_W-1:0] shreg;
    logic              pull;
    logic              first_pend;
    logic              fall;
    logic              rst_rel;
    logic              slot_done;
    logic              talking;
    logic              tx_bit;
    logic              my_bit;
    logic [BYTE_W-1:0] next_shreg;

    // ------------------------------------------------------------
    // Line input and derived events
    // ------------------------------------------------------------
    // Two-stage synchroniser; line_s and its delayed copy line_p feed logic
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_m <= 1'b1;
            line_s <= 1'b1;
            line_p <= 1'b1;
        end else begin
            line_m <= link.line;
            line_s <= line_m;
            line_p <= line_s;
        end
    end

    assign fall      = line_p & ~line_s;
    assign rst_rel   = rst_seen & line_s;
    assign slot_done = slot_act && (slot_cnt == DEV_WIN_CYC);
    assign my_bit    = ID_CODE[idx];
    // Device speaks in read slots and in the first two search slots
    assign talking   = (state == ST_READ) || ((state == ST_SRCH) && (phase != PH_WRITE));
    // (RULE_13) complement sent in second search slot
    assign tx_bit    = ((state == ST_SRCH) && (phase[0])) ? ~my_bit : my_bit;
    // (RULE_02) bits enter at the top, so byte ends LSB first
    assign next_shreg = {line_s, shreg[BYTE_W-1:1]};

    // ------------------------------------------------------------
    // Bus reset detection
    // ------------------------------------------------------------
    // (RULE_04) long low counted in every state
    // Counter saturates so an endless low cannot wrap into a false idle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt <= '0;
        end else if (line_s) begin
            low_cnt <= '0;
        end else if (low_cnt != RST_DET_CYC) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    // (RULE_20) reset noticed even mid-slot or deselected
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_seen <= 1'b0;
        end else if (line_s) begin
            rst_seen <= 1'b0;
        end else if (low_cnt == RST_DET_CYC) begin
            rst_seen <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Slot timing
    // ------------------------------------------------------------
    // (RULE_05) slot opens only on a falling edge, any pause allowed
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_act <= 1'b0;
            slot_cnt <= '0;
        end else if (rst_rel || state == ST_IDLE || state == ST_PRES) begin
            slot_act <= 1'b0;
            slot_cnt <= '0;
        end else if (!slot_act && fall) begin
            slot_act <= 1'b1;
            slot_cnt <= '0;
        end else if (slot_done) begin
            slot_act <= 1'b0;
        end else if (slot_act) begin
            slot_cnt <= slot_cnt + 1'b1;
        end
    end

    // Presence timer restarts on every reset release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pres_cnt <= '0;
        end else if (rst_rel || state != ST_PRES) begin
            pres_cnt <= '0;
        end else begin
            pres_cnt <= pres_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin driver
    // ------------------------------------------------------------
    // (RULE_03) only ever pulls low, otherwise released
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pull <= 1'b0;
        end else if (rst_rel || state == ST_IDLE) begin
            pull <= 1'b0;
        end else if (state == ST_PRES) begin
            // (RULE_07) presence low window after reset
            pull <= (pres_cnt >= PRES_WAIT_CYC) && (pres_cnt < PRES_END_CYC);
        end else if (!slot_act && fall) begin
            pull <= talking && !tx_bit;
        end else if (slot_done) begin
            pull <= 1'b0;
        end
    end

    assign link.dev_out = 1'b0;
    assign link.dev_oe  = pull;

    // ------------------------------------------------------------
    // Identity protocol
    // ------------------------------------------------------------
    // (RULE_06) sequence init, command, identity, function
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            idx        <= '0;
            phase      <= '0;
            bcnt       <= '0;
            shreg      <= '0;
            selected   <= 1'b0;
            first_pend <= 1'b0;
        end else if (rst_rel) begin
            // (RULE_20) abandon anything in progress
            state      <= ST_PRES;
            idx        <= '0;
            phase      <= '0;
            bcnt       <= '0;
            selected   <= 1'b0;
            first_pend <= 1'b0;
        end else if (state == ST_PRES) begin
            if (pres_cnt == PRES_END_CYC) begin
                state <= ST_CMD;
            end
        end else if (slot_done) begin
            case (state)
                ST_CMD: begin
                    // (RULE_08) act only after eight bits
                    shreg <= next_shreg;
                    bcnt  <= bcnt + 1'b1;
                    if (bcnt == BIT_LAST) begin
                        case (next_shreg)
                            CMD_READ_ID:   state <= ST_READ;
                            CMD_MATCH_ID:  state <= ST_MATCH;
                            CMD_SEARCH_ID: state <= ST_SRCH;
                            CMD_SKIP_ID: begin
                                // (RULE_12) select straight away
                                state      <= ST_FUNC;
                                selected   <= 1'b1;
                                first_pend <= 1'b1;
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end
                end
                ST_READ: begin
                    // (RULE_09) all 64 bits, family first
                    idx <= idx + 1'b1;
                    if (idx == IDX_LAST) begin
                        state      <= ST_FUNC;
                        selected   <= 1'b1;
                        first_pend <= 1'b1;
                    end
                end
                ST_MATCH: begin
                    idx <= idx + 1'b1;
                    if (line_s != my_bit) begin
                        // (RULE_11) wait for next reset
                        state <= ST_IDLE;
                    end else if (idx == IDX_LAST) begin
                        // (RULE_10) selected on full match
                        state      <= ST_FUNC;
                        selected   <= 1'b1;
                        first_pend <= 1'b1;
                    end
                end
                ST_SRCH: begin
                    if (phase != PH_WRITE) begin
                        phase <= phase + 1'b1;
                    end else begin
                        phase <= '0;
                        idx   <= idx + 1'b1;
                        if (line_s != my_bit) begin
                            // (RULE_14) drop out of the pass
                            state <= ST_IDLE;
                        end else if (idx == IDX_LAST) begin
                            state      <= ST_FUNC;
                            selected   <= 1'b1;
                            first_pend <= 1'b1;
                        end
                    end
                end
                ST_FUNC: begin
                    shreg <= next_shreg;
                    bcnt  <= bcnt + 1'b1;
                    if (bcnt == BIT_LAST) begin
                        first_pend <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Function byte hand-off
    // ------------------------------------------------------------
    // (RULE_18) bytes delivered only once selected
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            func_valid <= 1'b0;
            func_first <= 1'b0;
            func_byte  <= '0;
        end else if (slot_done && state == ST_FUNC && bcnt == BIT_LAST && !rst_seen) begin
            func_valid <= 1'b1;
            func_first <= first_pend;
            func_byte  <= next_shreg;
        end else begin
            func_valid <= 1'b0;
        end
    end

endmodule

/* File: hdl/swr_mst_end.sv */
/*
 * Master end of the single-wire identity link: bit-level engine with
 * reset/presence, write slot, read slot and one search triplet.
 * Assumes local logic builds bytes LSB first and waits for cmd_ready.
 */
`timescale 1ns/1ps
module swr_mst_end
    import swr_pkg::*;
#(
    parameter logic [CNT_W-1:0] RSTLOW_CYC = M_RSTLOW_CYC,
    parameter logic [CNT_W-1:0] INIT_CYC   = M_INIT_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    swr_link_if.mst         link,
    input  wire logic       cmd_valid,
    input  wire logic [1:0] cmd_op,
    input  wire logic       cmd_bit,
    output logic            cmd_ready,
    output logic            done,
    output logic            rd_bit,
    output logic            rd_cmp,
    output logic            presence,
    output logic            no_device
);

    // ------------------------------------------------------------
    // States and storage
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        M_IDLE = 3'h1,
        M_INIT = 3'h2,
        M_SLOT = 3'h4
    } swr_mst_e;

    swr_mst_e         state;
    logic             line_m;
    logic             line_s;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] low_len;
    logic [1:0]       op;
    logic [1:0]       trip;
    logic             wbit;
    logic             pull;
    logic             slot_end;
    logic             dir;

    // Two-stage synchroniser on the shared line
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_m <= 1'b1;
            line_s <= 1'b1;
        end else begin
            line_m <= link.line;
            line_s <= line_m;
        end
    end

    assign slot_end = (state == M_SLOT) && (cnt == M_SLOT_CYC);
    // Search pair decode: 01 -> 0, 10 -> 1, 00 -> caller's choice
    assign dir = (rd_bit ^ rd_cmp) ? rd_bit : wbit;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // (RULE_17) init of 960 us and 61 us slots
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= M_IDLE;
            cnt       <= '0;
            low_len   <= '0;
            op        <= OP_RESET;
            trip      <= '0;
            wbit      <= 1'b1;
            pull      <= 1'b0;
            cmd_ready <= 1'b1;
            done      <= 1'b0;
            rd_bit    <= 1'b1;
            rd_cmp    <= 1'b1;
            presence  <= 1'b0;
            no_device <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                M_IDLE: begin
                    if (cmd_valid) begin
                        op        <= cmd_op;
                        wbit      <= cmd_bit;
                        trip      <= '0;
                        cnt       <= '0;
                        pull      <= 1'b1;
                        cmd_ready <= 1'b0;
                        no_device <= 1'b0;
                        // (RULE_02) caller feeds bits LSB first
                        low_len   <= (cmd_op == OP_WRITE && !cmd_bit) ? M_LOW0_CYC : M_LOW1_CYC;
                        state     <= (cmd_op == OP_RESET) ? M_INIT : M_SLOT;
                    end
                end
                M_INIT: begin
                    // (RULE_07) reset pulse then presence sample
                    cnt <= cnt + 1'b1;
                    if (cnt == RSTLOW_CYC) begin
                        pull <= 1'b0;
                    end
                    if (cnt == RSTLOW_CYC + M_PSAMP_CYC) begin
                        presence <= ~line_s;
                    end
                    if (cnt == INIT_CYC) begin
                        state     <= M_IDLE;
                        cmd_ready <= 1'b1;
                        done      <= 1'b1;
                    end
                end
                M_SLOT: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == low_len) begin
                        pull <= 1'b0;
                    end
                    if (cnt == M_RSAMP_CYC && op != OP_WRITE) begin
                        if (op == OP_TRIPLET && trip == 2'h1) begin
                            rd_cmp <= line_s;
                        end else if (op != OP_TRIPLET || trip == 2'h0) begin
                            rd_bit <= line_s;
                        end
                    end
                    if (slot_end) begin
                        cnt <= '0;
                        if (op == OP_TRIPLET && trip == 2'h0) begin
                            trip <= 2'h1;
                            pull <= 1'b1;
                        end else if (op == OP_TRIPLET && trip == 2'h1) begin
                            // (RULE_15) both high means nobody answered
                            if (rd_bit && rd_cmp) begin
                                no_device <= 1'b1;
                                state     <= M_IDLE;
                                cmd_ready <= 1'b1;
                                done      <= 1'b1;
                            end else begin
                                trip    <= PH_WRITE;
                                wbit    <= dir;
                                pull    <= 1'b1;
                                low_len <= dir ? M_LOW1_CYC : M_LOW0_CYC;
                            end
                        end else begin
                            state     <= M_IDLE;
                            cmd_ready <= 1'b1;
                            done      <= 1'b1;
                        end
                    end
                end
                default: state <= M_IDLE;
            endcase
        end
    end

    assign link.mst_out = 1'b0;
    assign link.mst_oe  = pull;

endmodule

/* File: dv/swr_link_properties.sv */
/* Wire-level checks of the shared line.
   Assumes one clock and sys_rst for both ends. */
`timescale 1ns/1ps
module swr_link_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic mst_out,
    input wire logic mst_oe,
    input wire logic line
);
    // ------------------------------------------------------------
    // Pull run lengths
    // ------------------------------------------------------------
    logic [19:0] low_cnt;
    logic [19:0] fall_cnt;
    logic [19:0] dev_cnt;
    logic        long_rel;

    // No saturation: the run is far shorter than the counter range
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt  <= 20'h0;
            fall_cnt <= 20'h0;
            dev_cnt  <= 20'h0;
        end else begin
            low_cnt  <= mst_oe ? low_cnt + 20'h1 : 20'h0;
            fall_cnt <= mst_oe ? 20'h0 : fall_cnt + 20'h1;
            dev_cnt  <= dev_oe ? dev_cnt + 20'h1 : 20'h0;
        end
    end

    // Last master pull was a bus reset; write-0 pulls stay well below this
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            long_rel <= 1'b0;
        end else if (mst_oe) begin
            long_rel <= (low_cnt >= 20'd6000);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_dev_pulls_only: assert property (dev_out == 1'b0)
        else $error("device drives line high");
    a_mst_pulls_only: assert property (mst_out == 1'b0)
        else $error("master drives line high");
    a_line_wired_and: assert property (line == !(dev_oe || mst_oe))
        else $error("line is not wired-and");
    a_start_released: assert property ($fell(sys_rst) |-> !dev_oe && !mst_oe)
        else $error("pull right after reset");
    a_presence_delay: assert property (long_rel && fall_cnt == 20'd3050 |-> dev_oe)
        else $error("no presence pulse");
    a_quiet_in_reset: assert property (mst_oe && low_cnt > 20'd6000 |-> !dev_oe)
        else $error("device pulls in bus reset");
    a_pull_start_ok: assert property ($rose(dev_oe) |-> (mst_oe && low_cnt < 20'd8)
        || (fall_cnt > 20'd2980 && fall_cnt < 20'd3020))
        else $error("device pull on idle line");
    a_pull_width_ok: assert property ($fell(dev_oe) |-> dev_cnt < 20'd3002
        || (dev_cnt > 20'd11990 && dev_cnt < 20'd12010))
        else $error("device pull width wrong");
endmodule

/* File: dv/single_wire_rom_function_slave_bench.sv */
/* Bench: master end and device end on one line.
   Assumes shortened reset counts. */
`timescale 1ns/1ps
module single_wire_rom_function_slave_bench
    import swr_pkg::*;
;
    logic clk, sys_rst, cmd_valid, cmd_bit, cmd_ready, done, rd_bit, rd_cmp;
    logic presence, no_device, selected, func_valid, func_first, got_first, got_valid;
    logic [1:0] cmd_op;
    logic [7:0] func_byte, got_byte, fn;
    int fails, tests_run, cyc;

    swr_link_if link ();
    // Reset count must exceed write-0 low and the device's own presence width
    swr_mst_end #(.RSTLOW_CYC(20'd12600), .INIT_CYC(20'd28500)) u_swr_mst_end (.clk(clk),
        .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_bit(cmd_bit), .cmd_ready(cmd_ready), .done(done), .rd_bit(rd_bit),
        .rd_cmp(rd_cmp), .presence(presence), .no_device(no_device));
    swr_dev_end #(.RST_DET_CYC(20'd12500)) u_swr_dev_end (.clk(clk), .sys_rst(sys_rst),
        .link(link), .selected(selected), .func_valid(func_valid),
        .func_first(func_first), .func_byte(func_byte));
    swr_link_properties u_swr_link_properties (.clk(clk), .sys_rst(sys_rst),
        .dev_out(link.dev_out), .dev_oe(link.dev_oe), .mst_out(link.mst_out),
        .mst_oe(link.mst_oe), .line(link.line));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One master op; done is sampled mid-cycle to dodge edge races
    task automatic op(input logic [1:0] o, input logic b);
        cmd_valid <= 1'b1;
        cmd_op    <= o;
        cmd_bit   <= b;
        @(posedge clk);
        cmd_valid <= 1'b0;
        do @(negedge clk); while (done !== 1'b1);
        @(posedge clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Catch the one-cycle byte strobe
    always @(negedge clk) begin
        if (func_valid === 1'b1) begin
            got_valid = 1'b1;
            got_byte  = func_byte;
            got_first = func_first;
        end
    end

    // Hang guard: the run needs about 155k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 200000) begin
            fails++;
            results;
        end
    end

    // ------------------------------------------------------------
    // Reset, skip, one random function byte, reset mid-transaction
    // ------------------------------------------------------------
    initial begin
        {cmd_valid, cmd_bit, got_valid, got_first, got_byte} = '0;
        cmd_op  = OP_RESET;
        sys_rst = 1'b1;
        fn      = 8'($urandom(32'h5a37));
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        op(OP_RESET, 1'b0);
        check("presence", 8'h1, {7'h0, presence});
        for (int i = 0; i < 8; i++) begin
            if (i == 7) check("early select", 8'h0, {7'h0, selected});
            op(OP_WRITE, CMD_SKIP_ID[i]);
        end
        check("selected", 8'h1, {7'h0, selected});
        for (int i = 0; i < 8; i++) op(OP_WRITE, fn[i]);
        check("func valid", 8'h1, {7'h0, got_valid});
        check("func byte", fn, got_byte);
        check("func first", 8'h1, {7'h0, got_first});
        op(OP_RESET, 1'b0);
        check("presence again", 8'h1, {7'h0, presence});
        check("deselect", 8'h0, {7'h0, selected});
        results;
    end
endmodule
